// *** rtl/psa_pkg.sv ***
// Constants for the management register bank: addresses, field positions,
// reset values and frame timing.
// Assumes a serial management frame of start, opcode, two addresses, turnaround, data.
package psa_pkg;

  // Register addresses.
  localparam logic [4:0]  ADDR_BASIC_STATUS   = 5'h01;
  localparam logic [4:0]  ADDR_ORG_ID_HIGH    = 5'h02;
  localparam logic [4:0]  ADDR_ORG_ID_LOW     = 5'h03;
  localparam logic [4:0]  ADDR_AUTONEG_ADVERT = 5'h04;

  // Status bit positions.
  localparam int          ST_BIT_AN_DONE      = 5;
  localparam int          ST_BIT_REMOTE_FAULT = 4;
  localparam int          ST_BIT_LINK         = 2;
  localparam int          ST_BIT_JABBER       = 1;
  // Fixed status bits: 14..11, 8, 6, 3 and 0 set; 15, 10, 9 and 7 clear.
  localparam logic [15:0] ST_FIXED            = 16'h7949;

  // Advertisement layout.
  localparam logic [15:0] ADV_RESET           = 16'h01E1;
  localparam logic [15:0] ADV_WRITE_MASK      = 16'hBDE0;
  localparam logic [15:0] ADV_SELECTOR        = 16'h0001;

  // Frame constants.
  localparam logic [5:0]  PREAMBLE_BITS       = 6'd32;
  localparam logic [1:0]  OP_WRITE            = 2'b01;
  localparam logic [1:0]  OP_READ             = 2'b10;
  localparam logic [4:0]  OP_LAST             = 5'd1;
  localparam logic [4:0]  ADDR_LAST           = 5'd9;
  localparam logic [4:0]  DATA_LAST           = 5'd15;
  localparam logic [4:0]  DATA_BITS           = 5'd16;

  typedef enum logic [2:0] {
    FR_IDLE,
    FR_START,
    FR_OPCODE,
    FR_ADDR,
    FR_TA0,
    FR_TA1,
    FR_READ,
    FR_WRITE
  } psa_frame_type;

  typedef struct packed {
    logic          mdc_s1;
    logic          mdc_s2;
    logic          mdc_prev;
    logic          mdio_s1;
    logic          mdio_s2;
    psa_frame_type fr;
    logic [4:0]    cnt;
    logic [5:0]    pre_cnt;
    logic          synced;
    logic [1:0]    op;
    logic          addr_hit;
    logic [4:0]    reg_addr;
    logic [15:0]   sh;
    logic          mdio_oe;
    logic          mdio_out;
    logic [15:0]   adv;
    logic          link_lat;
    logic          rf_lat;
  } psa_state_type;

endpackage : psa_pkg

// *** rtl/psa_phy_status_advert_regs.sv ***
// Management register bank: basic status, organisation identifier and
// auto-negotiation advertisement, reached over the serial management pins.
// Assumes mdc_i and mdio_i come from outside the clock domain and that the
// status inputs come from logic on clock_i.
// Assumes the management clock stays high and low for at least three core
// clocks each, so that every rising edge is seen once after synchronising.
// The pin driver outside this block merges mdio_o into the line while
// mdio_oe_o is high.
`timescale 1ns/1ps

// Overview of operation
// - Status bit 15 always reads zero.
// - Status bits 14 to 11 read one.
// - Status bits 10 and 9 read zero.
// - Status bit 8 reads one.
// - Frames accepted without preamble after sync, until a frame is dropped.
// - Bit 5 shows negotiation done, pages valid.
// - Bit 4 latches remote fault, cleared on read.
// - Status bit 3 reads one.
// - Bit 2 holds link loss until read.
// - Bit 1 follows the jabber condition.
// - Bit 0 reads one, bit 7 zero.
// - Addresses 2 and 3 hold read-only identifier.
// - Advertisement bits 8 to 6 writable, default one.
// - Bits 13 and 15 writable, default zero.
// - Pause bits 11 and 10 writable, default zero.
// - Bit 9 zero; bit 14 reserved zero; bit 12 writable, default zero.
// - Bit 5 writable default one, selector 00001.
module psa_phy_status_advert_regs
  import psa_pkg::*;
#(
  parameter int          PHY_ADDR     = 1,       // Management address answered
  parameter logic [15:0] ORG_ID_UPPER = 16'h0A5A, // Arbitrary identifier value
  parameter logic [15:0] ORG_ID_LOWER = 16'h5A50  // Arbitrary identifier value
)
(
  input  wire logic        clock_i,            // Core clock, 250 MHz
  input  wire logic        resetn_i,           // Asynchronous reset, active low
  input  wire logic        clk_en_i,           // Freezes all state while low
  input  wire logic        mdc_i,              // Management clock pin
  input  wire logic        mdio_i,             // Management data pin, input side
  output logic             mdio_o,             // Management data pin, output side
  output logic             mdio_oe_o,          // High while the pin is driven
  input  wire logic        link_up_i,          // Link is up
  input  wire logic        jabber_i,           // Jabber condition present
  input  wire logic        far_end_fault_i,    // Far-end fault indication
  input  wire logic        lp_remote_fault_i,  // Partner reported remote fault
  input  wire logic        an_done_i,          // Auto-negotiation finished
  input  wire logic        lp_regs_valid_i,    // Partner page registers valid
  output logic [15:0]      autoneg_advertisement_o // Advertised code word
);

  if (PHY_ADDR < 0 || PHY_ADDR > 31)
  begin : g_addr_check
    $error("PHY_ADDR must lie in 0 to 31");
  end

  localparam logic [4:0] PHY_ADDR_5 = 5'(PHY_ADDR);

  psa_state_type s_q;
  psa_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode.
  // The status word mixes fixed capability bits with live and latched
  // conditions; it is captured once per read, at the first turnaround bit,
  // so that every data bit of one frame comes from the same snapshot.

  function automatic logic [15:0] status_word(
    input logic an_ok,
    input logic rf,
    input logic link,
    input logic jab
  );
    logic [15:0] w;
    w = ST_FIXED;
    w[ST_BIT_AN_DONE]      = an_ok;
    w[ST_BIT_REMOTE_FAULT] = rf;
    w[ST_BIT_LINK]         = link;
    w[ST_BIT_JABBER]       = jab;
    return w;
  endfunction : status_word

  function automatic logic [15:0] read_word(
    input logic [4:0]  ra,
    input logic [15:0] stat,
    input logic [15:0] adv
  );
    logic [15:0] w;
    case (ra)
      ADDR_BASIC_STATUS:   w = stat;
      ADDR_ORG_ID_HIGH:    w = ORG_ID_UPPER;
      ADDR_ORG_ID_LOW:     w = ORG_ID_LOWER;
      ADDR_AUTONEG_ADVERT: w = adv;
      default:             w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // Abandons the frame in progress. The station must send a full preamble
  // before the next frame is taken, because the bit stream can no longer be
  // trusted to be in step with the frame layout.
  function automatic psa_state_type drop_frame(
    input psa_state_type s
  );
    psa_state_type r;
    r        = s;
    r.fr     = FR_IDLE;
    r.synced = 1'b0;
    return r;
  endfunction : drop_frame

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // A management bit is taken only on a detected rising edge of the
  // management clock; between edges the frame state stands still, so a
  // stopped link clock simply pauses the frame.
  logic        mdc_rise;
  logic        bit_in;
  logic [9:0]  addr_bits;
  logic [15:0] stat_now;
  logic        read_done;

  always_comb
  begin
    s_d       = s_q;
    mdc_rise  = s_q.mdc_s2 & ~s_q.mdc_prev;
    bit_in    = s_q.mdio_s2;
    addr_bits = {s_q.sh[8:0], bit_in};
    read_done = 1'b0;
    stat_now  = status_word(an_done_i & lp_regs_valid_i, s_q.rf_lat,
                            s_q.link_lat, jabber_i);

    // Only the second flop of each synchroniser feeds logic.
    s_d.mdc_s1   = mdc_i;
    s_d.mdc_s2   = s_q.mdc_s1;
    s_d.mdc_prev = s_q.mdc_s2;
    s_d.mdio_s1  = mdio_i;
    s_d.mdio_s2  = s_q.mdio_s1;

    if (mdc_rise)
    begin
      case (s_q.fr)
        // Counts ones of preamble until the link is in step; after that a
        // zero is taken as the first start bit of the next frame.
        FR_IDLE:
        begin
          s_d.mdio_oe = 1'b0;
          if (bit_in)
          begin
            if (s_q.pre_cnt != PREAMBLE_BITS)
            begin
              s_d.pre_cnt = s_q.pre_cnt + 6'd1;
            end
            if (s_q.pre_cnt == PREAMBLE_BITS - 6'd1)
            begin
              s_d.synced = 1'b1;
            end
          end
          else
          begin
            s_d.pre_cnt = 6'd0;
            if (s_q.synced)
            begin
              s_d.fr = FR_START;
            end
          end
        end
        // The second start bit must be one; anything else means the link
        // has slipped, so the preamble is needed again.
        FR_START:
        begin
          s_d.cnt = 5'd0;
          s_d.fr  = bit_in ? FR_OPCODE : FR_IDLE;
          if (!bit_in)
          begin
            s_d.synced = 1'b0;
          end
        end
        // Two opcode bits, most significant first; only read and write are
        // valid, and an invalid code drops the frame.
        FR_OPCODE:
        begin
          s_d.op  = {s_q.op[0], bit_in};
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt == OP_LAST)
          begin
            s_d.cnt = 5'd0;
            if ({s_q.op[0], bit_in} == OP_READ || {s_q.op[0], bit_in} == OP_WRITE)
            begin
              s_d.fr = FR_ADDR;
            end
            else
            begin
              s_d = drop_frame(s_d);
            end
          end
        end
        // Ten address bits: the device address first, then the register
        // address. Frames for another device are followed to their end so
        // that the next start bit is found, but they drive and write nothing.
        FR_ADDR:
        begin
          s_d.sh  = {s_q.sh[14:0], bit_in};
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt == ADDR_LAST)
          begin
            s_d.addr_hit = (addr_bits[9:5] == PHY_ADDR_5);
            s_d.reg_addr = addr_bits[4:0];
            s_d.fr       = FR_TA0;
          end
        end
        // First turnaround bit. For a read to this device the pin is taken
        // here and the answer word is captured.
        FR_TA0:
        begin
          // The controller releases the line during a read turnaround.
          if (s_q.op == OP_WRITE && !bit_in)
          begin
            s_d = drop_frame(s_d);
          end
          else
          begin
            s_d.fr = FR_TA1;
          end
          if (s_q.op == OP_READ && s_q.addr_hit)
          begin
            s_d.mdio_oe  = 1'b1;
            s_d.mdio_out = 1'b0;
            s_d.sh       = read_word(s_q.reg_addr, stat_now, s_q.adv);
          end
        end
        // Second turnaround bit. A read puts out the first data bit here; a
        // write must see zero, or the frame is dropped as invalid.
        // Data bits follow most significant first.
        FR_TA1:
        begin
          s_d.cnt = 5'd0;
          if (s_q.op == OP_READ)
          begin
            s_d.fr       = FR_READ;
            s_d.mdio_out = s_q.sh[15];
            s_d.sh       = {s_q.sh[14:0], 1'b0};
            s_d.cnt      = 5'd1;
          end
          else if (bit_in)
          begin
            s_d = drop_frame(s_d);
          end
          else
          begin
            s_d.fr = FR_WRITE;
          end
        end
        // Each rise shifts out the next bit; after the last bit has stood
        // for one full link clock period the pin is released and the read
        // counts as complete.
        FR_READ:
        begin
          if (s_q.cnt == DATA_BITS)
          begin
            s_d.mdio_oe = 1'b0;
            s_d.fr      = FR_IDLE;
            read_done   = s_q.addr_hit && (s_q.reg_addr == ADDR_BASIC_STATUS);
          end
          else
          begin
            s_d.mdio_out = s_q.sh[15];
            s_d.sh       = {s_q.sh[14:0], 1'b0};
            s_d.cnt      = s_q.cnt + 5'd1;
          end
        end
        // Sixteen data bits are shifted in; the register changes only once
        // the last bit has arrived, never part way through a frame.
        FR_WRITE:
        begin
          s_d.sh  = {s_q.sh[14:0], bit_in};
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt == DATA_LAST)
          begin
            s_d.fr = FR_IDLE;
            if (s_q.addr_hit && s_q.reg_addr == ADDR_AUTONEG_ADVERT)
            begin
              // Only writable fields change; bit 9, bit 14 and the selector hold.
              s_d.adv = ({s_q.sh[14:0], bit_in} & ADV_WRITE_MASK) | ADV_SELECTOR;
            end
          end
        end
        // All eight state codes are used, so this branch is never reached; it would release
        // the pin and return to idle to wait for the next start bit.
        default:
        begin
          s_d.fr      = FR_IDLE;
          s_d.mdio_oe = 1'b0;
        end
      endcase
    end

    // Link drop is held low until a status read; a new event beats the clear.
    if (read_done)
    begin
      s_d.link_lat = link_up_i;
      s_d.rf_lat   = far_end_fault_i | lp_remote_fault_i;
    end
    else
    begin
      s_d.link_lat = s_q.link_lat & link_up_i;
      s_d.rf_lat   = s_q.rf_lat | far_end_fault_i | lp_remote_fault_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  // Reset releases the pin, forgets any preamble already seen and restores
  // the advertisement defaults. While the clock enable is low every field,
  // synchronisers included, holds its value.

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q          <= '0;
      s_q.fr       <= FR_IDLE;
      s_q.mdc_prev <= 1'b0;
      s_q.adv      <= ADV_RESET;
    end
    else if (clk_en_i)
    begin
      s_q <= s_d;
    end
  end

  // All outputs come straight from flip-flops, so the pin never glitches
  // while the frame state changes.
  assign mdio_o                  = s_q.mdio_out;
  assign mdio_oe_o               = s_q.mdio_oe;
  assign autoneg_advertisement_o = s_q.adv;

endmodule : psa_phy_status_advert_regs

// *** bench/psa_phy_status_advert_regs_chk.sv ***
`timescale 1ns/1ps
// Port checker for the management register bank.
// Assumes one link bit lasts 8 core clocks.
module psa_chk
  import psa_pkg::*;
(
  input wire logic        clock_i,                // Clock
  input wire logic        resetn_i,               // Reset
  input wire logic        mdc_i,                  // Link clock
  input wire logic        mdio_o,                 // Data out
  input wire logic        mdio_oe_o,              // Drive enable
  input wire logic [15:0] autoneg_advertisement_o // Advert
);
  logic [7:0] hi_q;
  logic [5:0] mh_q;
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      {hi_q, mh_q} <= 14'h0000;
    else
      {hi_q, mh_q} <= {mdio_oe_o ? hi_q + 8'h01 : 8'h00, mh_q[4:0], mdc_i};
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  sequence ta_s;
    !mdio_o ##1 mdio_oe_o [*8];
  endsequence
  sequence hold_s;
    $stable(mdio_o) [*6];
  endsequence
  oe_start_a: assert property ($rose(mdio_oe_o) |-> ta_s)
    else $error("turnaround drive wrong");
  oe_length_a: assert property ($fell(mdio_oe_o) |-> hi_q >= 8'h84 && hi_q <= 8'h8C)
    else $error("drive length wrong");
  oe_clock_a: assert property ($changed(mdio_oe_o) |-> |mh_q)
    else $error("drive change without link clock");
  bit_hold_a: assert property (mdio_oe_o && $changed(mdio_o) |=> hold_s)
    else $error("data bit not held");
  adv_fixed_a: assert property (autoneg_advertisement_o[14] == 1'b0 &&
    autoneg_advertisement_o[9] == 1'b0 && autoneg_advertisement_o[4:0] == 5'h01)
    else $error("fixed advert bits wrong");
  adv_reset_a: assert property ($rose(resetn_i) |-> autoneg_advertisement_o == 16'h01E1)
    else $error("advert reset value wrong");
  adv_read_a: assert property (mdio_oe_o |-> $stable(autoneg_advertisement_o))
    else $error("advert changed in read");
  adv_write_a: assert property ($changed(autoneg_advertisement_o) |=>
    $stable(autoneg_advertisement_o) [*8])
    else $error("advert changed twice");
endmodule : psa_chk
bind psa_phy_status_advert_regs psa_chk u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .mdc_i(mdc_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
  .autoneg_advertisement_o(autoneg_advertisement_o));

// *** bench/psa_mgmt_ctl.sv ***
`timescale 1ns/1ps
// Station model: sends management frames and reads the answer.
// Assumes 8 clocks a bit; the released data line is pulled up.
module psa_mgmt_ctl
  import psa_pkg::*;
(
  input  wire logic clock_i,  // Pace clock
  input  wire logic dev_i,    // Device data
  input  wire logic dev_oe_i, // Device drive
  output logic      mdc_o,    // Link clock
  output logic      line_o    // Data line
);
  logic drv_q = 1'b0;
  logic bit_q = 1'b1;
  assign line_o = dev_oe_i ? dev_i : (drv_q ? bit_q : 1'b1);
  initial mdc_o = 1'b0;
  task automatic xfer(input logic pre, input logic [11:0] hdr, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [63:0] w;
    w = {32'hFFFF_FFFF, 2'b01, hdr, 2'b10, wd};
    rd = 16'h0000;
    for (int i = pre ? 63 : 31; i >= 0; i--)
    begin
      @(posedge clock_i);
      mdc_o <= 1'b0;
      drv_q <= (hdr[11:10] != OP_READ) || (i > 17);
      bit_q <= w[i];
      repeat (4) @(posedge clock_i);
      mdc_o <= 1'b1;
      if (i < 16)
        rd[i] = line_o;
      repeat (3) @(posedge clock_i);
    end
    @(posedge clock_i);
    {mdc_o, drv_q} <= 2'b00;
  endtask : xfer
endmodule : psa_mgmt_ctl

// *** bench/psa_phy_status_advert_regs_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the management register bank.
// Assumes the station model and the bound checker.
module psa_phy_status_advert_regs_tb
  import psa_pkg::*;
;
  typedef struct packed {logic [1:0] op; logic [4:0] ra; logic [15:0] wd, ex;} psa_row_type;
  localparam logic [15:0] ID_HI = 16'h3C3C; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'hC3C3; // Arbitrary value
  localparam logic [15:0] STB   = ST_FIXED | 16'h0024;
  logic        clock_i = 1'b0, resetn_i = 1'b0, mdc, line, dout, doe;
  logic        lnk = 1'b1, jab = 1'b0, far = 1'b0, lprf = 1'b0, an = 1'b1, lpv = 1'b1;
  logic [15:0] adv, rd;
  int          failures = 0, checks_done = 0, cyc = 0;
  psa_row_type rows [12] = '{
    '{OP_READ, 5'h1, 16'h0, STB},
    '{OP_WRITE, 5'h2, 16'hFFFF, 16'h0},
    '{OP_READ, 5'h2, 16'h0, ID_HI},
    '{OP_READ, 5'h3, 16'h0, ID_LO},
    '{OP_READ, 5'h4, 16'h0, 16'h01E1},
    '{OP_WRITE, 5'h4, 16'hFFFF, 16'h0},
    '{OP_READ, 5'h4, 16'h0, 16'hBDE1},
    '{OP_WRITE, 5'h1, 16'hFFFF, 16'h0},
    '{OP_READ, 5'h1, 16'h0, STB},
    '{OP_READ, 5'h5, 16'h0, 16'h0},
    '{OP_WRITE, 5'h4, 16'h0, 16'h0},
    '{OP_READ, 5'h4, 16'h0, 16'h0001}
  };
  always #2 clock_i = ~clock_i;
  psa_phy_status_advert_regs #(.PHY_ADDR(1), .ORG_ID_UPPER(ID_HI), .ORG_ID_LOWER(ID_LO)) u_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .mdc_i(mdc), .mdio_i(line),
    .mdio_o(dout), .mdio_oe_o(doe), .link_up_i(lnk), .jabber_i(jab), .far_end_fault_i(far),
    .lp_remote_fault_i(lprf), .an_done_i(an), .lp_regs_valid_i(lpv),
    .autoneg_advertisement_o(adv));
  psa_mgmt_ctl u_sm (.clock_i(clock_i), .dev_i(dout), .dev_oe_i(doe), .mdc_o(mdc),
    .line_o(line));
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    checks_done++;
    if (got !== ex)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, ex);
    end
  endtask : chk
  task automatic rw(input logic pre, input logic [1:0] op, input logic [4:0] ra,
                    input logic [15:0] wd, input logic [15:0] ex);
    u_sm.xfer(pre, {op, 5'h1, ra}, wd, rd);
    if (op == OP_READ)
      chk(rd, ex);
  endtask : rw
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    rw(1'b1, OP_READ, 5'h1, 16'h0, ST_FIXED | 16'h0020);
    for (int i = 0; i < 12; i++)
      rw(1'b0, rows[i].op, rows[i].ra, rows[i].wd, rows[i].ex);
    chk(adv, 16'h0001);
    $display("table test done");
    {jab, lpv} <= 2'b10;
    rw(1'b0, OP_READ, 5'h1, 16'h0, ST_FIXED | 16'h0006);
    {jab, lpv, an} <= 3'b010;
    rw(1'b0, OP_READ, 5'h1, 16'h0, ST_FIXED | 16'h0004);
    an <= 1'b1;
    $display("live bits test done");
    for (int k = 0; k < 2; k++)
    begin
      {lprf, far, lnk} <= k ? 3'b101 : 3'b010;
      @(posedge clock_i);
      {lprf, far, lnk} <= 3'b001;
      rw(1'b0, OP_READ, 5'h1, 16'h0, k ? STB | 16'h0010 : ST_FIXED | 16'h0030);
      rw(1'b0, OP_READ, 5'h1, 16'h0, STB);
    end
    $display("latch test done");
    far <= 1'b1;
    @(posedge clock_i);
    {far, resetn_i} <= 2'b00;
    repeat (5) @(posedge clock_i);
    chk(adv, 16'h01E1);
    resetn_i <= 1'b1;
    rw(1'b0, OP_READ, 5'h4, 16'h0, 16'hFFFF);
    rw(1'b1, OP_READ, 5'h1, 16'h0, ST_FIXED | 16'h0020);
    u_sm.xfer(1'b0, {2'b11, 5'h1, 5'h1}, 16'h0, rd);
    rw(1'b0, OP_READ, 5'h4, 16'h0, 16'hFFFF);
    u_sm.xfer(1'b1, {OP_READ, 5'h2, 5'h4}, 16'h0, rd);
    chk(rd, 16'hFFFF);
    rw(1'b0, OP_READ, 5'h4, 16'h0, 16'h01E1);
    $display("refusal test done");
    final_report();
  end
endmodule : psa_phy_status_advert_regs_tb
